// ===== apd_pkg.sv
// shared constants, register map and carriers of the power detector thresholds
package apd_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] IX_C0H_LO = 10'h00f;
  localparam logic [9:0] IX_C0H_HI = 10'h010;
  localparam logic [9:0] IX_C0L_LO = 10'h011;
  localparam logic [9:0] IX_C0L_HI = 10'h012;
  localparam logic [9:0] IX_FMT0 = 10'h013;
  localparam logic [9:0] IX_C1H_LO = 10'h016;
  localparam logic [9:0] IX_C1H_HI = 10'h017;
  localparam logic [9:0] IX_C1L_LO = 10'h018;
  localparam logic [9:0] IX_C1L_HI = 10'h019;
  localparam logic [9:0] IX_FMT1 = 10'h01a;
  localparam logic [9:0] IX_HOLD_LO = 10'h01d;
  localparam logic [9:0] IX_HOLD_HI = 10'h01e;
  localparam logic [9:0] IX_PEN = 10'h020;
  localparam logic [9:0] IX_PEXP = 10'h021;
  localparam logic [9:0] IX_PH_LO = 10'h022;
  localparam logic [9:0] IX_PH_HI = 10'h023;
  localparam logic [9:0] IX_PL_LO = 10'h024;
  localparam logic [9:0] IX_PL_HI = 10'h025;
  localparam logic [9:0] IX_STAT = 10'h040;
  localparam logic [9:0] IX_MASK = 10'h041;
  localparam logic [9:0] IX_LIVE = 10'h042;

  // field layout
  localparam int unsigned PEXP_W = 5;
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_FLAG0 = 0;
  localparam int unsigned EV_FLAG1 = 1;
  localparam int unsigned EV_PHIGH = 2;
  localparam int unsigned EV_PLOW = 3;

  // [R2] unity and one-eighth crossing ratio codes
  localparam logic signed [15:0] THR_UNITY = 16'sh4000;
  localparam logic signed [15:0] THR_EIGHTH = 16'sh0800;

  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } apd_wb_req_s;

  typedef struct packed {
    logic signed [15:0] iir0;
    logic signed [15:0] iir1;
    logic [15:0] pwr;
  } apd_sense_s;

  typedef struct packed {
    logic signed [15:0] c0h;
    logic signed [15:0] c0l;
    logic signed [15:0] c1h;
    logic signed [15:0] c1l;
    logic fmt0;
    logic fmt1;
    logic [15:0] hold;
    logic pen;
    logic [PEXP_W-1:0] pexp;
    logic [15:0] ph;
    logic [15:0] pl;
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic [1:0] flag;
    logic [15:0] cnt0;
    logic [15:0] cnt1;
    logic [31:0] pacc;
    logic [16:0] pcnt;
    logic phi;
    logic plo;
    logic [1:0] res0;
    logic [1:0] res1;
    logic irq;
    logic ack;
    logic [31:0] rdat;
  } apd_state_s;

  localparam apd_state_s ST_RST = '0;

endpackage

// ===== apd_top.sv
// power detector thresholds: crossing comparators, hold timer, average power, registers
//
// Behaviour
// [R1] crossing thresholds are signed 2.14 values
// [R2] 4000h is 100%, 0800h is 12.5%
// [R3] format bit selects 1-bit or 2-bit result
// [R4] output above upper limit sets peak flag
// [R5] flag clears after full hold below lower
// [R6] hold count is 16 bits of clocks
// [R7] average power runs only while enabled
// [R8] power block length is 2 to the M
// [R9] low byte at lower index, high next
// [R10] average power compared to 16-bit limits
// [R11] software writes zero to unused bits
// [R12] hold count restarts when back at lower
//
// Register access over Wishbone is this design's own decision.
module apd_top #(
  parameter int unsigned PWR_EXP_MAX = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register bus
  input apd_pkg::apd_wb_req_s wb_req,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // filtered samples, one per clock
  input apd_pkg::apd_sense_s sense,
  // detector results
  output logic [1:0] iir0_result,
  output logic [1:0] iir1_result,
  output logic [1:0] power_result,
  output logic irq
);
  import apd_pkg::*;

  if (PWR_EXP_MAX < 1 || PWR_EXP_MAX > 16) begin : g_chk
    $error("PWR_EXP_MAX must lie in 1..16");
  end

  apd_state_s q;
  apd_state_s d;

  // one hold step: returns {flag, count}
  function automatic logic [16:0] hold_step(
    input logic signed [15:0] smp,
    input logic signed [15:0] hi,
    input logic signed [15:0] lo,
    input logic [15:0] hold,
    input logic flag,
    input logic [15:0] cnt
  );
    logic [16:0] r;
    r = {flag, 16'h0000};
    // [R4] upper crossing sets flag
    if (smp > hi) begin
      r = {1'b1, 16'h0000};
    end else if (flag && smp < lo) begin
      // [R5] clear after full hold
      if (cnt >= hold) begin
        r = {1'b0, 16'h0000};
      end else begin
        // [R6] count hold clocks
        r = {1'b1, cnt + 16'h0001};
      end
    end
    // [R12] otherwise count restarts
    return r;
  endfunction

  // result bits: hysteresis flag, and in two-level format the below-lower level
  function automatic logic [1:0] fmt_res(
    input logic two,
    input logic flag,
    input logic below
  );
    // [R3] one or two bit format
    return two ? {below, flag} : {1'b0, flag};
  endfunction

  // read data byte for an index
  function automatic logic [7:0] rd_byte(input apd_state_s s, input logic [9:0] ix);
    logic [7:0] b;
    b = 8'h00;
    case (ix)
      IX_C0H_LO: b = s.c0h[7:0];
      IX_C0H_HI: b = s.c0h[15:8];
      IX_C0L_LO: b = s.c0l[7:0];
      IX_C0L_HI: b = s.c0l[15:8];
      IX_FMT0: b = {7'h00, s.fmt0};
      IX_C1H_LO: b = s.c1h[7:0];
      IX_C1H_HI: b = s.c1h[15:8];
      IX_C1L_LO: b = s.c1l[7:0];
      IX_C1L_HI: b = s.c1l[15:8];
      IX_FMT1: b = {7'h00, s.fmt1};
      IX_HOLD_LO: b = s.hold[7:0];
      IX_HOLD_HI: b = s.hold[15:8];
      IX_PEN: b = {7'h00, s.pen};
      IX_PEXP: b = {3'h0, s.pexp};
      IX_PH_LO: b = s.ph[7:0];
      IX_PH_HI: b = s.ph[15:8];
      IX_PL_LO: b = s.pl[7:0];
      IX_PL_HI: b = s.pl[15:8];
      IX_STAT: b = {4'h0, s.stat};
      IX_MASK: b = {4'h0, s.mask};
      IX_LIVE: b = {s.plo, s.phi, 4'h0, s.flag};
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  logic [9:0] idx;
  logic take;
  logic wr;
  logic rd;
  logic [7:0] wb;
  logic [16:0] h0;
  logic [16:0] h1;
  logic [EV_W-1:0] ev;
  logic [PEXP_W-1:0] m;
  logic [16:0] blk;
  logic [31:0] sum;
  logic [31:0] avg;
  logic nphi;
  logic nplo;

  always_comb begin
    d = q;
    idx = wb_req.adr[11:2];
    take = wb_req.cyc & wb_req.stb & ~q.ack;
    wr = take & wb_req.we & wb_req.sel[0];
    rd = take & ~wb_req.we;
    wb = wb_req.dat[7:0];
    d.ack = take;
    d.rdat = rd ? {24'h000000, rd_byte(q, idx)} : q.rdat;

    // crossing comparators
    // [R1] signed limits
    h0 = hold_step(sense.iir0, q.c0h, q.c0l, q.hold, q.flag[0], q.cnt0);
    h1 = hold_step(sense.iir1, q.c1h, q.c1l, q.hold, q.flag[1], q.cnt1);
    d.flag = {h1[16], h0[16]};
    d.cnt0 = h0[15:0];
    d.cnt1 = h1[15:0];
    d.res0 = fmt_res(q.fmt0, h0[16], sense.iir0 < q.c0l);
    d.res1 = fmt_res(q.fmt1, h1[16], sense.iir1 < q.c1l);

    // average power over a block
    // [R8] clamp exponent to supported range
    m = (q.pexp > PEXP_W'(PWR_EXP_MAX)) ? PEXP_W'(PWR_EXP_MAX) : q.pexp;
    blk = 17'h00001 << m;
    sum = q.pacc + {16'h0000, sense.pwr};
    avg = sum >> m;
    nphi = q.phi;
    nplo = q.plo;
    // [R7] held idle while disabled
    if (!q.pen) begin
      d.pacc = 32'h00000000;
      d.pcnt = 17'h00000;
      nphi = 1'b0;
      nplo = 1'b0;
    end else if (q.pcnt == blk - 17'h00001) begin
      // [R10] compare block average
      nphi = avg > {16'h0000, q.ph};
      nplo = avg < {16'h0000, q.pl};
      d.pacc = 32'h00000000;
      d.pcnt = 17'h00000;
    end else begin
      d.pacc = sum;
      d.pcnt = q.pcnt + 17'h00001;
    end
    d.phi = nphi;
    d.plo = nplo;

    // sticky events, read clears, a new event wins
    ev = '0;
    ev[EV_FLAG0] = h0[16] & ~q.flag[0];
    ev[EV_FLAG1] = h1[16] & ~q.flag[1];
    ev[EV_PHIGH] = nphi & ~q.phi;
    ev[EV_PLOW] = nplo & ~q.plo;
    d.stat = ((rd && idx == IX_STAT) ? '0 : q.stat) | ev;

    // register writes
    // [R9] byte halves of 16-bit limits
    if (wr) begin
      case (idx)
        IX_C0H_LO: d.c0h[7:0] = wb;
        IX_C0H_HI: d.c0h[15:8] = wb;
        IX_C0L_LO: d.c0l[7:0] = wb;
        IX_C0L_HI: d.c0l[15:8] = wb;
        IX_C1H_LO: d.c1h[7:0] = wb;
        IX_C1H_HI: d.c1h[15:8] = wb;
        IX_C1L_LO: d.c1l[7:0] = wb;
        IX_C1L_HI: d.c1l[15:8] = wb;
        IX_HOLD_LO: d.hold[7:0] = wb;
        IX_HOLD_HI: d.hold[15:8] = wb;
        IX_PH_LO: d.ph[7:0] = wb;
        IX_PH_HI: d.ph[15:8] = wb;
        IX_PL_LO: d.pl[7:0] = wb;
        IX_PL_HI: d.pl[15:8] = wb;
        // [R11] unused bits not stored
        IX_FMT0: d.fmt0 = wb[0];
        IX_FMT1: d.fmt1 = wb[0];
        IX_PEN: d.pen = wb[0];
        IX_PEXP: d.pexp = wb[PEXP_W-1:0];
        IX_MASK: d.mask = wb[EV_W-1:0];
        default: d.mask = q.mask;
      endcase
    end
    d.irq = |(d.stat & d.mask);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign iir0_result = q.res0;
  assign iir1_result = q.res1;
  assign power_result = {q.plo, q.phi};
  assign irq = q.irq;

endmodule // apd_top

// ===== apd_chk_sva.sv
// port assertions of the power detector thresholds
module apd_chk
  import apd_pkg::*;
(
  // clock, reset
  input wire logic clock,
  input wire logic rst_n,
  // bus
  input apd_pkg::apd_wb_req_s wb_req,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // detector
  input apd_pkg::apd_sense_s sense,
  input wire logic [1:0] iir0_result,
  input wire logic [1:0] iir1_result,
  input wire logic [1:0] power_result,
  input wire logic irq
);
  logic [7:0] sh_q [128];
  wire logic wr_en = wb_req.cyc && wb_req.stb && wb_req.we && wb_req.sel[0] && !wb_ack_o;
  wire logic signed [15:0] c0h = {sh_q[7'h10], sh_q[7'h0f]};
  wire logic signed [15:0] c0l = {sh_q[7'h12], sh_q[7'h11]};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // shadow of bytes written below index 0x080
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) sh_q <= '{default: 8'h00};
    else if (wr_en && wb_req.adr[11:9] == 3'h0) sh_q[wb_req.adr[8:2]] <= wb_req.dat[7:0];
  end
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_flag_sets: assert property (sense.iir0 > c0h |=> iir0_result[0])
    else $error("flag not set");
  a_flag_kept: assert property (iir0_result[0] && sense.iir0 >= c0l |=> iir0_result[0])
    else $error("flag lost");
  a_below_shown: assert property (sh_q[7'h13][0] && sense.iir0 < c0l |=> iir0_result[1])
    else $error("below bit low");
  a_one_bit: assert property (!sh_q[7'h13][0] |=> !iir0_result[1])
    else $error("below bit high");
  a_power_off: assert property (!sh_q[7'h20][0] [*2] |=> power_result == 2'b00)
    else $error("power active");
  a_irq_masked: assert property (sh_q[7'h41][3:0] == 4'h0 && !wr_en |=> !irq)
    else $error("irq masked");
  c_flag_set: cover property ($rose(iir0_result[0]));
  c_flag_clear: cover property ($fell(iir0_result[0]));
  c_power_high: cover property (power_result == 2'b01);
endmodule // apd_chk
bind apd_top apd_chk u_chk (.clock(clock), .rst_n(rst_n), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .sense(sense), .iir0_result(iir0_result), .iir1_result(iir1_result),
  .power_result(power_result), .irq(irq));

// ===== tb.sv
// self-checking bench of the power detector thresholds
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import apd_pkg::*;
  logic clock, rst_n, wb_ack_o, irq;
  logic [31:0] wb_dat_o;
  logic [1:0] iir0_result, iir1_result, power_result;
  apd_wb_req_s wb_req;
  apd_sense_s sense;
  int errors, checks_done;
  apd_top u_dut (.clock(clock), .rst_n(rst_n), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .sense(sense), .iir0_result(iir0_result),
    .iir1_result(iir1_result), .power_result(power_result), .irq(irq));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [9:0] ix, input logic [7:0] d,
    output logic [31:0] q);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {ix, 2'b00}, sel: 4'h1, dat: {24'h0, d}};
    @(posedge clock);
    while (wb_ack_o !== 1'b1) @(posedge clock);
    q = wb_dat_o;
    wb_req <= '0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, ix, d, q);
  endtask
  task automatic rd(input logic [9:0] ix, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, ix, 8'h00, q);
    chk(q, {24'h0, e});
  endtask
  task automatic t_regs;
    rd(IX_C0H_LO, RST_BYTE);
    rd(IX_HOLD_HI, RST_BYTE);
    wr(IX_C1L_LO, 8'h34);
    wr(IX_C1L_HI, 8'hc2);
    rd(IX_C1L_LO, 8'h34);
    rd(IX_C1L_HI, 8'hc2);
    wr(IX_FMT0, 8'h01);
    rd(IX_FMT0, 8'h01);
    wr(IX_PEXP, 8'h1f);
    rd(IX_PEXP, 8'h1f);
    wr(10'h07f, 8'h5a);
    rd(10'h07f, 8'h00);
  endtask
  task automatic t_cross;
    wr(IX_C0H_HI, 8'h08);
    wr(IX_C0L_HI, 8'h04);
    wr(IX_HOLD_LO, 8'h02);
    wr(IX_MASK, 8'h01);
    sense.iir0 <= THR_UNITY;
    sense.iir1 <= THR_UNITY;
    repeat (3) @(posedge clock);
    chk(iir0_result, 32'h1);
    chk(iir1_result, 32'h1);
    sense.iir0 <= 16'sh0100;
    repeat (2) @(posedge clock);
    chk(iir0_result, 32'h3);
    sense.iir0 <= 16'sh0600;
    repeat (2) @(posedge clock);
    chk(iir0_result, 32'h1);
    sense.iir0 <= 16'sh0100;
    repeat (3) @(posedge clock);
    chk(iir0_result, 32'h3);
    repeat (2) @(posedge clock);
    chk(iir0_result, 32'h2);
    chk(irq, 32'h1);
    rd(IX_STAT, 8'h03);
    @(posedge clock);
    chk(irq, 32'h0);
  endtask
  task automatic t_power;
    wr(IX_PH_HI, 8'h01);
    wr(IX_PL_LO, 8'h10);
    wr(IX_PEXP, 8'h02);
    sense.pwr <= 16'h0200;
    wr(IX_PEN, 8'h01);
    repeat (12) @(posedge clock);
    chk(power_result, 32'h1);
    sense.pwr <= 16'h0001;
    repeat (12) @(posedge clock);
    chk(power_result, 32'h2);
    wr(IX_PEN, 8'h00);
    repeat (2) @(posedge clock);
    chk(power_result, 32'h0);
  endtask
  task automatic complete_run;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    complete_run();
  end
  initial begin
    wb_req = '0;
    sense = '0;
    rst_n = 1'b0;
    errors = 0;
    checks_done = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_cross();
    t_power();
    complete_run();
  end
endmodule // tb
